// file: verilog/cst_ctrl.sv
// Transfer control: register port, start logic, repeat reservation and completion
`timescale 1ns/100ps
`include "cst_defs.svh"
module cst_ctrl #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [`CST_AW-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Serial link
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Status
  output logic transfer_active,
  output logic transfer_done_irq
);

  cst_pkg::cst_ctrl_t ctrl;
  cst_pkg::cst_run_state_t state;
  logic [DIV_W-1:0] half_div;
  logic [15:0] tx_buf;
  logic [15:0] initial_tx;
  logic [15:0] rx_buf;
  logic reserved;
  logic keep_going;
  logic rsv_open;
  logic phase_err;
  logic sck_meta;
  logic sck_sync;
  logic sdi_meta;
  logic sdi_sync;
  logic sh_last;
  logic sh_done;
  logic sh_sck;
  logic sh_sdo;
  logic [15:0] sh_word;

  // Register access decode
  wire wr_ctrl = reg_wr & (reg_addr == `CST_OFF_CTRL);
  wire wr_div = reg_wr & (reg_addr == `CST_OFF_DIV);
  wire wr_txw = reg_wr & (reg_addr == `CST_OFF_TX_WORD);
  wire wr_txl = reg_wr & (reg_addr == `CST_OFF_TX_LOW);
  wire wr_initw = reg_wr & (reg_addr == `CST_OFF_INIT_WORD);
  wire wr_initl = reg_wr & (reg_addr == `CST_OFF_INIT_LOW);
  wire rd_rxw = reg_rd & (reg_addr == `CST_OFF_RX_WORD);
  wire rd_rxl = reg_rd & (reg_addr == `CST_OFF_RX_LOW);

  wire slave = (ctrl.clock_source_select == `CST_SLAVE_CLK);
  wire idle = (state == cst_pkg::cst_idle);
  wire rep = ctrl.repeat_select;

  // Next values of the aliased buffers
  // low view alias
  wire [15:0] next_tx_buf = wr_txw ? reg_wdata : (wr_txl ? {tx_buf[15:8], reg_wdata[7:0]} : tx_buf);
  wire [15:0] next_initial_tx = wr_initw ? reg_wdata :
    (wr_initl ? {initial_tx[15:8], reg_wdata[7:0]} : initial_tx);

  // Start requests; initial buffer and peek or shift reads never appear here
  // transmit write starts
  wire tx_req = ctrl.tx_rx_select & (wr_txw | wr_txl);
  wire rx_req = ~ctrl.tx_rx_select & (rd_rxw | rd_rxl);
  wire req_acc = ctrl.unit_enable & (tx_req | rx_req);

  // access on the done cycle restarts
  wire start_new = req_acc & (idle | (sh_done & ~(rep & keep_going)));
  wire cont = sh_done & rep & keep_going & ~start_new;
  wire sh_start = start_new | cont;

  wire rsv_hit = req_acc & rsv_open & ~sh_last & rep;

  // first repeat word from initial buffer
  wire [15:0] start_word = ~ctrl.tx_rx_select ? `CST_WORD_RST :
    ((rep & start_new) ? initial_tx : (start_new ? next_tx_buf : tx_buf));

  wire dly_eff = ctrl.irq_delay_select & ~slave;

  wire [15:0] rd_mux =
    (reg_addr == `CST_OFF_CTRL) ? {transfer_active, phase_err, 5'h00, ctrl} :
    (reg_addr == `CST_OFF_RX_WORD || reg_addr == `CST_OFF_PEEK_WORD) ? rx_buf :
    (reg_addr == `CST_OFF_RX_LOW || reg_addr == `CST_OFF_PEEK_LOW) ? {8'h00, rx_buf[7:0]} :
    (reg_addr == `CST_OFF_TX_WORD) ? tx_buf :
    (reg_addr == `CST_OFF_TX_LOW) ? {8'h00, tx_buf[7:0]} :
    (reg_addr == `CST_OFF_INIT_WORD) ? initial_tx :
    (reg_addr == `CST_OFF_INIT_LOW) ? {8'h00, initial_tx[7:0]} :
    (reg_addr == `CST_OFF_SHIFT_WORD) ? sh_word :
    (reg_addr == `CST_OFF_SHIFT_LOW) ? {8'h00, sh_word[7:0]} :
    (reg_addr == `CST_OFF_DIV) ? {{(16-DIV_W){1'b0}}, half_div} : `CST_WORD_RST;

  assign transfer_active = ~idle;
  assign sck_oe = ctrl.unit_enable & ~slave;
  assign sdo_oe = ctrl.unit_enable & ctrl.tx_rx_select;
  assign sck_out = sh_sck;
  assign sdo = sh_sdo;

  // Two-stage synchronisers for the link pins
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_meta <= 1'b1;
      sck_sync <= 1'b1;
      sdi_meta <= 1'b0;
      sdi_sync <= 1'b0;
    end
    else if (ce)
    begin
      sck_meta <= sck_in;
      sck_sync <= sck_meta;
      sdi_meta <= sdi;
      sdi_sync <= sdi_meta;
    end
  end

  // Software registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= cst_pkg::cst_ctrl_t'(`CST_CTRL_RST);
      half_div <= DIV_W'(`CST_DIV_RST);
      tx_buf <= `CST_WORD_RST;
      initial_tx <= `CST_WORD_RST;
      reg_rdata <= `CST_WORD_RST;
    end
    else if (ce)
    begin
      if (wr_ctrl)
        ctrl <= cst_pkg::cst_ctrl_t'(reg_wdata[`CST_CTRL_W-1:0]);
      if (wr_div)
        half_div <= reg_wdata[DIV_W-1:0];
      tx_buf <= next_tx_buf;
      initial_tx <= next_initial_tx;
      reg_rdata <= reg_rd ? rd_mux : `CST_WORD_RST;
    end
  end

  // Sequencing of words and reservation
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= cst_pkg::cst_idle;
      reserved <= 1'b0;
      keep_going <= 1'b0;
      rsv_open <= 1'b0;
    end
    else if (ce)
    begin
      if (!ctrl.unit_enable)
      begin
        state <= cst_pkg::cst_idle;
        reserved <= 1'b0;
        keep_going <= 1'b0;
        rsv_open <= 1'b0;
      end
      else
      begin
        if (sh_start)
          state <= cst_pkg::cst_run;
        // back to idle after the word
        else if (sh_done)
          state <= cst_pkg::cst_idle;
        if (start_new)
          reserved <= rep;
        else if (sh_last)
          reserved <= 1'b0;
        else if (rsv_hit)
          reserved <= 1'b1;
        if (start_new)
          keep_going <= 1'b0;
        else if (sh_last)
          keep_going <= reserved;
        if (cont)
          rsv_open <= 1'b1;
        else if (sh_last || start_new)
          rsv_open <= 1'b0;
      end
    end
  end

  // Receive buffer, completion pulse and phase error flag
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_buf <= `CST_WORD_RST;
      transfer_done_irq <= 1'b0;
      phase_err <= 1'b0;
    end
    else if (ce)
    begin
      transfer_done_irq <= sh_done;
      if (!ctrl.unit_enable)
        rx_buf <= `CST_WORD_RST;
      else if (sh_done && (!rep || keep_going))
        rx_buf <= sh_word;
      // Set wins over a same-cycle clear
      if (start_new && sh_done && slave)
        phase_err <= 1'b1;
      else if (wr_ctrl && reg_wdata[`CST_BIT_PHERR])
        phase_err <= 1'b0;
    end
  end

  cst_shifter #(
    .DIV_W(DIV_W)
  ) u_shifter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .enable(ctrl.unit_enable),
    .start(sh_start),
    .load_word(start_word),
    .wide(ctrl.length_select),
    .lsb_first(ctrl.first_bit_select),
    .slave(slave),
    .delay(dly_eff),
    .half_div(half_div),
    .sck_sync(sck_sync),
    .sdi_sync(sdi_sync),
    .sck_out(sh_sck),
    .sdo(sh_sdo),
    .last_bit(sh_last),
    .done(sh_done),
    .shift_word(sh_word)
  );

  a_tx_write_starts: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && idle && ctrl.unit_enable && ctrl.tx_rx_select && wr_txl |=> transfer_active)
    else $error("transmit low write did not start a transfer");

  a_low_alias_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && wr_txl |=> tx_buf[7:0] == $past(reg_wdata[7:0]) && tx_buf[15:8] == $past(tx_buf[15:8]))
    else $error("transmit low view does not alias the word buffer");

  a_init_no_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && idle && (wr_initw || wr_initl) |=> !transfer_active)
    else $error("initial buffer write started a transfer");

  a_peek_no_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && idle && reg_rd && !rd_rxw && !rd_rxl |=> !transfer_active)
    else $error("non-starting read started a transfer");

  a_shift_cleared: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && !ctrl.unit_enable |=> sh_word == `CST_WORD_RST && rx_buf == `CST_WORD_RST)
    else $error("shift or receive data survive unit disable");

  a_rx_read_starts: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && idle && ctrl.unit_enable && !ctrl.tx_rx_select && rd_rxw |=> transfer_active)
    else $error("receive read did not start a transfer");

  a_done_irq_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && ctrl.unit_enable && sh_done && !sh_start |=> transfer_done_irq && !transfer_active)
    else $error("word end without interrupt or with active still set");

  a_delay_master: assert property (@(posedge clk_sys) disable iff (!rst_n)
    slave |-> u_shifter.state != cst_pkg::cst_sh_tail)
    else $error("interrupt delay applied in slave mode");

  a_repeat_two_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && start_new && rep |=> reserved && !keep_going)
    else $error("repeat start did not hold a second request");

  a_stop_no_update: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && ctrl.unit_enable && sh_done && rep && !keep_going |=> rx_buf == $past(rx_buf))
    else $error("stopped repeat stream updated the receive buffer");

  a_clear_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && ctrl.unit_enable && sh_last && !reserved && !start_new |=> !keep_going && !reserved)
    else $error("access at the clear point kept the stream going");

  a_restart_on_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && sh_done && rep && !keep_going && req_acc |=> transfer_active && !keep_going)
    else $error("access on the done cycle did not restart");

  a_window_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && ctrl.unit_enable && rsv_hit && !start_new |=> reserved)
    else $error("access inside the reservation period was lost");

  c_single_word: cover property (@(posedge clk_sys) disable iff (!rst_n)
    sh_done && !rep);
  c_repeat_cont: cover property (@(posedge clk_sys) disable iff (!rst_n)
    cont ##[1:1000] cont);
  c_repeat_restart: cover property (@(posedge clk_sys) disable iff (!rst_n)
    sh_done && start_new && rep);

endmodule

// file: verilog/cst_defs.svh
// Register offsets, field positions and reset values for the serial transfer control
//Behaviour
//- In transmit/receive mode a write of the low transmit view starts a transfer
//- Low transmit view shares storage with the lower byte of the transmit word
//- Initial transmit word holds the first repeat word; writing it starts nothing
//- Initial transmit low view aliases its lower byte and starts nothing either
//- Shift word is readable by software and reading it starts nothing
//- Shift low view is the lower byte; both clear on reset and unit disable
//- In receive-only mode a read of the receive word or low view starts transfer
//- Transfer active flag rises as soon as a transfer starts
//- Each finished word raises the done interrupt; unless a next word starts at once, it drops active, then waits
//- Interrupt delay mode is valid only as clock master, never in slave mode
//- Starting a repeat sequence registers two pending transfer requests at once
//- Repeat receive continues only if receive word or low view is read inside the reservation period
//- Repeat transmit continues only on a timely transmit write; else last word stays shifted
//- Access coinciding with the request clear is ignored and the transfer stops
//- Access coinciding with the done interrupt starts a new repeat sequence
//- Receive peek views return the receive buffer without starting anything
`ifndef CST_DEFS_SVH
`define CST_DEFS_SVH

`define CST_AW 4
`define CST_OFF_CTRL 4'h0
`define CST_OFF_RX_WORD 4'h1
`define CST_OFF_RX_LOW 4'h2
`define CST_OFF_PEEK_WORD 4'h3
`define CST_OFF_PEEK_LOW 4'h4
`define CST_OFF_TX_WORD 4'h5
`define CST_OFF_TX_LOW 4'h6
`define CST_OFF_INIT_WORD 4'h7
`define CST_OFF_INIT_LOW 4'h8
`define CST_OFF_SHIFT_WORD 4'h9
`define CST_OFF_SHIFT_LOW 4'ha
`define CST_OFF_DIV 4'hb

`define CST_CTRL_W 9
`define CST_BIT_ACTIVE 15
`define CST_BIT_PHERR 14
`define CST_SLAVE_CLK 3'h7

`define CST_CTRL_RST 9'h000
`define CST_WORD_RST 16'h0000
`define CST_DIV_RST 8'h04

`endif

// file: verilog/cst_pkg.sv
// Types shared by the serial transfer control files
package cst_pkg;

  typedef struct packed {
    logic [2:0] clock_source_select;
    logic irq_delay_select;
    logic first_bit_select;
    logic repeat_select;
    logic length_select;
    logic tx_rx_select;
    logic unit_enable;
  } cst_ctrl_t;

  typedef enum logic [1:0] {
    cst_idle = 2'b01,
    cst_run = 2'b10
  } cst_run_state_t;

  typedef enum logic [2:0] {
    cst_sh_idle = 3'b001,
    cst_sh_shift = 3'b010,
    cst_sh_tail = 3'b100
  } cst_sh_state_t;

endpackage

// file: verilog/cst_shifter.sv
// Bit engine: serial clock, shift register and bit counter for one word
`timescale 1ns/100ps
`include "cst_defs.svh"
module cst_shifter #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Control
  input wire logic enable,
  input wire logic start,
  input wire logic [15:0] load_word,
  input wire logic wide,
  input wire logic lsb_first,
  input wire logic slave,
  input wire logic delay,
  input wire logic [DIV_W-1:0] half_div,
  // Synchronised link inputs
  input wire logic sck_sync,
  input wire logic sdi_sync,
  // Link outputs
  output logic sck_out,
  output logic sdo,
  // Status
  output logic last_bit,
  output logic done,
  output logic [15:0] shift_word
);

  cst_pkg::cst_sh_state_t state;
  logic [DIV_W-1:0] tick_cnt;
  logic [3:0] bits_left;
  logic sck_prev;
  logic end_pend;

  function automatic logic out_bit(input logic [15:0] s, input logic w, input logic lsb);
    out_bit = lsb ? s[0] : (w ? s[15] : s[7]);
  endfunction

  function automatic logic [15:0] shift_in(input logic [15:0] s, input logic d,
                                          input logic w, input logic lsb);
    if (lsb)
      shift_in = w ? {d, s[15:1]} : {8'h00, d, s[7:1]};
    else
      shift_in = w ? {s[14:0], d} : {8'h00, s[6:0], d};
  endfunction

  wire [DIV_W:0] tick_next = {1'b0, tick_cnt} + {{DIV_W{1'b0}}, 1'b1};
  wire tick = (tick_next >= {1'b0, half_div});
  wire shifting = (state == cst_pkg::cst_sh_shift);
  wire fall_edge = shifting & (slave ? (sck_prev & ~sck_sync) : (tick & sck_out));
  wire rise_edge = shifting & (slave ? (~sck_prev & sck_sync) : (tick & ~sck_out));
  wire final_bit = (bits_left == 4'h0);
  wire [3:0] first_count = wide ? 4'hf : 4'h7;

  // Clear point lies half a bit before the end of the word
  assign last_bit = fall_edge & final_bit;
  // Done a cycle after the last rise, or a half bit later in delay mode, once the word holds its final bit
  assign done = end_pend | ((state == cst_pkg::cst_sh_tail) & tick);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= cst_pkg::cst_sh_idle;
      tick_cnt <= '0;
      bits_left <= 4'h0;
      sck_prev <= 1'b1;
      end_pend <= 1'b0;
      sck_out <= 1'b1;
      sdo <= 1'b1;
      shift_word <= `CST_WORD_RST;
    end
    else if (ce)
    begin
      sck_prev <= sck_sync;
      end_pend <= enable & rise_edge & final_bit & ~delay;
      tick_cnt <= (tick || state == cst_pkg::cst_sh_idle) ? '0 : tick_next[DIV_W-1:0];
      if (!enable)
      begin
        state <= cst_pkg::cst_sh_idle;
        bits_left <= 4'h0;
        sck_out <= 1'b1;
        sdo <= 1'b1;
        shift_word <= `CST_WORD_RST;
      end
      else if (start)
      begin
        state <= cst_pkg::cst_sh_shift;
        bits_left <= first_count;
        sck_out <= 1'b1;
        shift_word <= load_word;
        sdo <= out_bit(load_word, wide, lsb_first);
      end
      else
      begin
        if (!slave && shifting && tick)
          sck_out <= ~sck_out;
        if (fall_edge)
          sdo <= out_bit(shift_word, wide, lsb_first);
        if (rise_edge)
        begin
          shift_word <= shift_in(shift_word, sdi_sync, wide, lsb_first);
          bits_left <= bits_left - 4'h1;
        end
        if (rise_edge && final_bit)
          state <= delay ? cst_pkg::cst_sh_tail : cst_pkg::cst_sh_idle;
        else if (state == cst_pkg::cst_sh_tail && tick)
          state <= cst_pkg::cst_sh_idle;
      end
    end
  end

endmodule

// file: tb/cst_peer.sv
// Serial peer model: shifts its word out, captures the device's word, clocks as master
`timescale 1ns/100ps
module cst_peer (
  // Control
  input wire logic rst_n,
  input wire logic [4:0] nbits,
  input wire logic [15:0] tx_word,
  // Link
  input wire logic sck,
  input wire logic sdo,
  output logic sdi,
  output logic sck_drv,
  // Result
  output logic [15:0] rx_word
);
  int cnt;
  logic [15:0] out_sh;
  logic [15:0] in_sh;

  initial
  begin
    sdi = 1'b1;
    sck_drv = 1'b1;
    rx_word = 16'h0000;
    in_sh = 16'h0000;
    out_sh = 16'h0000;
    cnt = 0;
  end

  // Data moves on the falling edge; the word is taken at the first one
  always @(negedge sck)
  begin
    if (rst_n === 1'b1)
    begin
      if (cnt == 0)
        out_sh = tx_word << (16 - nbits);
      sdi = out_sh[15];
      out_sh = out_sh << 1;
    end
  end

  // Sampled on the rising edge
  always @(posedge sck)
  begin
    if (rst_n === 1'b1)
    begin
      in_sh = {in_sh[14:0], sdo};
      cnt = cnt + 1;
      if (cnt == nbits)
      begin
        cnt = 0;
        rx_word = (nbits == 5'd16) ? in_sh : {8'h00, in_sh[7:0]};
        // Hold time over: stale level must not look valid
        sdi <= #90 ~sdi;
      end
    end
  end

  // Clock stands high between frames
  task automatic clock_frame(input int n);
    repeat (n)
    begin
      #100 sck_drv = 1'b0;
      #100 sck_drv = 1'b1;
    end
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the serial transfer control block
`timescale 1ns/100ps
`include "cst_defs.svh"
module testbench;
  logic clk_sys, rst_n, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, peer_tx, peer_rx, rd_val;
  logic sck_out, sck_oe, sdo, sdo_oe, sdi, peer_sck, link_sck, link_sdo;
  logic transfer_active, transfer_done_irq;
  logic ce;
  logic [4:0] peer_bits;
  int n_fail;
  int checked;

  assign link_sck = sck_oe ? sck_out : peer_sck;
  assign link_sdo = sdo_oe ? sdo : 1'b1;

  cst_ctrl i_cst_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sck_in(link_sck), .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .transfer_active(transfer_active),
    .transfer_done_irq(transfer_done_irq));

  cst_peer i_cst_peer (.rst_n(rst_n), .nbits(peer_bits), .tx_word(peer_tx), .sck(link_sck),
    .sdo(link_sdo), .sdi(sdi), .sck_drv(peer_sck), .rx_word(peer_rx));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Control word with unit enabled; delay and bit order left at zero
  function automatic logic [15:0] ctl(input logic [2:0] cs, input logic rep, input logic len,
    input logic trx);
    ctl = {7'h00, cs, 2'b00, rep, len, trx, 1'b1};
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  task automatic rd_cmp(input string what, input logic [3:0] a, input logic [15:0] exp);
    rd(a);
    cmp(what, exp, rd_val);
  endtask

  task automatic chk_act(input logic exp);
    #1;
    cmp("transfer_active", {15'h0000, exp}, {15'h0000, transfer_active});
  endtask

  task automatic wait_irq();
    int i;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge clk_sys);
      #1;
      if (transfer_done_irq === 1'b1)
        break;
    end
    if (i == 3000)
    begin
      cmp("irq wait", 16'h0001, 16'h0000);
      tally_and_finish();
    end
  endtask

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    peer_bits = 5'd8;
    peer_tx = 16'h0000;
    n_fail = 0;
    checked = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_cmp("ctrl", `CST_OFF_CTRL, 16'h0000);
    rd_cmp("divider", `CST_OFF_DIV, 16'h0004);
    rd_cmp("shift word", `CST_OFF_SHIFT_WORD, 16'h0000);
    wr(4'hf, 16'hffff);
    rd_cmp("unmapped", 4'hf, 16'h0000);
    cmp("oe pins", 16'h0000, {14'h0000, sck_oe, sdo_oe});
    $display("test reset values done");
    wr(`CST_OFF_TX_WORD, 16'h1234);
    wr(`CST_OFF_TX_LOW, 16'h00ab);
    rd_cmp("tx word", `CST_OFF_TX_WORD, 16'h12ab);
    wr(`CST_OFF_INIT_WORD, 16'h5678);
    wr(`CST_OFF_INIT_LOW, 16'h00cd);
    rd_cmp("init word", `CST_OFF_INIT_WORD, 16'h56cd);
    rd_cmp("init low", `CST_OFF_INIT_LOW, 16'h00cd);
    wr(`CST_OFF_SHIFT_WORD, 16'hbeef);
    rd_cmp("shift ro", `CST_OFF_SHIFT_WORD, 16'h0000);
    // Clock enable low must freeze the buffers
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(`CST_OFF_TX_WORD, 16'hffff);
    ce <= 1'b1;
    rd_cmp("frozen tx word", `CST_OFF_TX_WORD, 16'h12ab);
    $display("test buffer views done");
    wr(`CST_OFF_CTRL, ctl(3'h0, 1'b0, 1'b0, 1'b1));
    rd_cmp("ctrl", `CST_OFF_CTRL, ctl(3'h0, 1'b0, 1'b0, 1'b1));
    cmp("oe pins", 16'h0003, {14'h0000, sck_oe, sdo_oe});
    wr(`CST_OFF_INIT_WORD, 16'h0077);
    chk_act(1'b0);
    wr(`CST_OFF_INIT_LOW, 16'h0077);
    chk_act(1'b0);
    rd(`CST_OFF_SHIFT_WORD);
    chk_act(1'b0);
    rd(`CST_OFF_PEEK_LOW);
    chk_act(1'b0);
    peer_tx = 16'h00c5;
    wr(`CST_OFF_TX_LOW, 16'h003a);
    chk_act(1'b1);
    wait_irq();
    chk_act(1'b0);
    @(posedge clk_sys);
    #1;
    cmp("irq pulse", 16'h0000, {15'h0000, transfer_done_irq});
    cmp("peer got", 16'h003a, peer_rx);
    rd_cmp("rx low", `CST_OFF_RX_LOW, 16'h00c5);
    rd_cmp("shift low", `CST_OFF_SHIFT_LOW, 16'h00c5);
    rd_cmp("peek low", `CST_OFF_PEEK_LOW, 16'h00c5);
    $display("test single transmit done");
    wr(`CST_OFF_CTRL, ctl(3'h0, 1'b0, 1'b0, 1'b1) | 16'h0020);
    peer_tx = 16'h0096;
    wr(`CST_OFF_TX_LOW, 16'h0069);
    chk_act(1'b1);
    wait_irq();
    chk_act(1'b0);
    cmp("delayed peer got", 16'h0069, peer_rx);
    rd_cmp("delayed rx low", `CST_OFF_RX_LOW, 16'h0096);
    $display("test delay mode done");
    wr(`CST_OFF_CTRL, ctl(3'h0, 1'b0, 1'b1, 1'b0));
    peer_bits = 5'd16;
    peer_tx = 16'ha55a;
    rd(`CST_OFF_RX_WORD);
    chk_act(1'b1);
    wait_irq();
    chk_act(1'b0);
    rd_cmp("peek word", `CST_OFF_PEEK_WORD, 16'ha55a);
    chk_act(1'b0);
    rd_cmp("shift word", `CST_OFF_SHIFT_WORD, 16'ha55a);
    rd_cmp("shift low", `CST_OFF_SHIFT_LOW, 16'h005a);
    wr(`CST_OFF_CTRL, 16'h0004);
    rd_cmp("shift cleared", `CST_OFF_SHIFT_WORD, 16'h0000);
    rd_cmp("rx cleared", `CST_OFF_PEEK_WORD, 16'h0000);
    $display("test single receive done");
    peer_bits = 5'd8;
    wr(`CST_OFF_CTRL, ctl(3'h0, 1'b1, 1'b0, 1'b1));
    peer_tx = 16'h00a1;
    wr(`CST_OFF_INIT_LOW, 16'h0011);
    chk_act(1'b0);
    wr(`CST_OFF_TX_LOW, 16'h0022);
    chk_act(1'b1);
    wait_irq();
    peer_tx = 16'h00a2;
    chk_act(1'b1);
    cmp("peer word 1", 16'h0011, peer_rx);
    wr(`CST_OFF_TX_LOW, 16'h0033);
    rd_cmp("rx word 1", `CST_OFF_RX_LOW, 16'h00a1);
    wait_irq();
    peer_tx = 16'h00a3;
    chk_act(1'b1);
    cmp("peer word 2", 16'h0022, peer_rx);
    wait_irq();
    chk_act(1'b0);
    cmp("peer word 3", 16'h0033, peer_rx);
    rd_cmp("rx kept", `CST_OFF_PEEK_LOW, 16'h00a2);
    rd_cmp("last word", `CST_OFF_SHIFT_LOW, 16'h00a3);
    $display("test repeat transmit done");
    wr(`CST_OFF_CTRL, ctl(3'h0, 1'b1, 1'b0, 1'b0));
    peer_tx = 16'h00b1;
    rd(`CST_OFF_RX_LOW);
    chk_act(1'b1);
    wait_irq();
    peer_tx = 16'h00b2;
    rd_cmp("rx word 1", `CST_OFF_RX_LOW, 16'h00b1);
    wait_irq();
    peer_tx = 16'h00b3;
    chk_act(1'b1);
    wait_irq();
    chk_act(1'b0);
    rd_cmp("rx kept", `CST_OFF_PEEK_LOW, 16'h00b2);
    rd_cmp("last word", `CST_OFF_SHIFT_LOW, 16'h00b3);
    $display("test repeat receive done");
    // Enabled before the peer clocks; delay mode left clear
    wr(`CST_OFF_CTRL, ctl(3'h7, 1'b0, 1'b0, 1'b1));
    #1;
    cmp("slave oe", 16'h0001, {14'h0000, sck_oe, sdo_oe});
    peer_tx = 16'h00c3;
    wr(`CST_OFF_TX_LOW, 16'h005c);
    chk_act(1'b1);
    i_cst_peer.clock_frame(8);
    wait_irq();
    chk_act(1'b0);
    cmp("peer got", 16'h005c, peer_rx);
    rd_cmp("rx low", `CST_OFF_RX_LOW, 16'h00c3);
    $display("test slave transfer done");
    tally_and_finish();
  end
endmodule
